// ---- hw/sbd_decode.v ----
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "sbd_defs.vh"
module sbd_decode #(
  parameter AW = 23
)(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        acc_valid,
  input  wire [31:0] acc_addr,
  input  wire        acc_write,
  input  wire [5:0]  acc_type,
  input  wire        cs_match,
  input  wire        col_phase,
  output reg  [1:0]  blk_hit,
  output reg         addr_exc,
  output reg         ext_cycle,
  output reg         page_mode,
  output reg  [1:0]  port_size,
  output reg         map_ok,
  output reg  [AW-1:0] sdram_addr,
  output wire        irq
);
  reg  [31:0] mask_reg [0:1];
  reg  [31:0] ctrl_reg [0:1];
  reg  [3:0]  irq_stat;
  reg  [3:0]  irq_mask;
  reg  [31:0] lat_addr;
  reg         lat_blk;
  wire [1:0]  raw_hit;
  wire [1:0]  prot;
  wire        wr_en;
  reg         rd_ok;
  wire        any_hit;
  wire        any_prot;
  wire        sel_blk;
  wire [1:0]  win_hit;
  wire [3:0]  ev;
  reg  [31:0] next_prdata;
  reg  [AW-1:0] next_sdram_addr;
  wire [AW+31:0] pad_addr;
  wire [AW-1:0] row9;
  wire [AW-1:0] row10;
  wire [AW-1:0] col9;
  wire [AW-1:0] col10;

  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  always @*
  begin
    rd_ok = 1'b0;
    if (paddr == `SBD_OFF_MASK0)
      rd_ok = 1'b1;
    else if (paddr == `SBD_OFF_MASK1)
      rd_ok = 1'b1;
    else if (paddr == `SBD_OFF_CTRL0)
      rd_ok = 1'b1;
    else if (paddr == `SBD_OFF_CTRL1)
      rd_ok = 1'b1;
    else if (paddr == `SBD_OFF_IRQ_STAT)
      rd_ok = 1'b1;
    else if (paddr == `SBD_OFF_IRQ_MASK)
      rd_ok = 1'b1;
    else if (paddr == `SBD_OFF_HIT_STAT)
      rd_ok = 1'b1;
  end
  // unmapped addresses answer with an error and change nothing
  assign pslverr = psel & penable & ~rd_ok;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : blk
      wire [13:0] base_addr_mask   = mask_reg[g][`SBD_BAM_HI:`SBD_BAM_LO];
      wire [13:0] base  = ctrl_reg[g][`SBD_BASE_HI:`SBD_BASE_LO];
      // masked bits drop out of the compare, need not be contiguous
      wire        amatch = (((acc_addr[31:18] ^ base) & ~base_addr_mask) == 14'h0000);
      wire        tok    = ((acc_type & mask_reg[g][`SBD_ATM_HI:`SBD_ATM_LO]) == 6'h00);
      assign raw_hit[g] = acc_valid & mask_reg[g][`SBD_VALID_BIT] & amatch & tok;
      assign prot[g]    = raw_hit[g] & acc_write & mask_reg[g][`SBD_WP_BIT];
    end
  endgenerate

  // one writer for both register pairs avoids split drivers on the arrays
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_reg[0] <= `SBD_MASK_RST;
      mask_reg[1] <= `SBD_MASK_RST;
      ctrl_reg[0] <= `SBD_CTRL_RST;
      ctrl_reg[1] <= `SBD_CTRL_RST;
    end
    else if (wr_en)
    begin
      // reserved bits are not stored and read back as zero
      if (paddr == `SBD_OFF_MASK0)
        mask_reg[0] <= pwdata & 32'hFFFC017F;
      else if (paddr == `SBD_OFF_MASK1)
        mask_reg[1] <= pwdata & 32'hFFFC017F;
      else if (paddr == `SBD_OFF_CTRL0)
        ctrl_reg[0] <= pwdata & 32'hFFFC0035;
      else if (paddr == `SBD_OFF_CTRL1)
        ctrl_reg[1] <= pwdata & 32'hFFFC0035;
    end
  end

  // block 0 wins when both blocks overlap; the losing block never counts
  assign win_hit  = {raw_hit[1] & ~raw_hit[0], raw_hit[0]};
  assign sel_blk  = ~raw_hit[0];
  assign any_hit  = |(win_hit & ~prot);
  assign any_prot = |(win_hit & prot);
  assign ev[`SBD_EV_EXC]  = any_prot & ~cs_match;
  assign ev[`SBD_EV_EXT]  = any_prot & cs_match;
  assign ev[`SBD_EV_MISS] = acc_valid & ~(|raw_hit);
  assign ev[`SBD_EV_W]    = 1'b0;
  assign irq = |(irq_stat & irq_mask);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat <= 4'h0;
    else
    begin
      // a new event beats a clearing write in the same cycle
      if (wr_en && paddr == `SBD_OFF_IRQ_STAT)
        irq_stat <= (irq_stat & ~pwdata[3:0]) | ev;
      else
        irq_stat <= irq_stat | ev;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= 4'h0;
    else if (wr_en && paddr == `SBD_OFF_IRQ_MASK)
      irq_mask <= pwdata[3:0];
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blk_hit   <= 2'h0;
      addr_exc  <= 1'b0;
      ext_cycle <= 1'b0;
    end
    else
    begin
      blk_hit   <= win_hit & ~prot;
      addr_exc  <= ev[`SBD_EV_EXC];
      ext_cycle <= ev[`SBD_EV_EXT];
    end
  end

  // address held for the row and column phases of the access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lat_addr <= 32'h00000000;
      lat_blk  <= 1'b0;
    end
    else if (any_hit)
    begin
      lat_addr <= acc_addr;
      lat_blk  <= sel_blk;
    end
  end

  // zero padding lets the upper lines run past address bit 31
  assign pad_addr = {{AW{1'b0}}, lat_addr};

  generate
    for (g = 0; g < AW; g = g + 1)
    begin : line
      if (g < 9)
      begin : low
        assign row9[g]  = pad_addr[17-g];
        assign row10[g] = pad_addr[17-g];
        assign col9[g]  = pad_addr[g];
        assign col10[g] = pad_addr[g];
      end
      else if (g == 9)
      begin : mid
        assign row9[g]  = pad_addr[18];
        assign row10[g] = pad_addr[19];
        assign col9[g]  = 1'b0;
        assign col10[g] = pad_addr[18];
      end
      else
      begin : high
        assign row9[g]  = pad_addr[g+9];
        assign row10[g] = pad_addr[g+10];
        assign col9[g]  = 1'b0;
        assign col10[g] = 1'b0;
      end
    end
  endgenerate

  always @*
  begin
    next_sdram_addr = {AW{1'b0}};
    // only the 8-bit port mapping exists here; other sizes drive zero
    if (ctrl_reg[lat_blk][`SBD_PS_HI:`SBD_PS_LO] == `SBD_PS_8BIT)
    begin
      if (ctrl_reg[lat_blk][`SBD_COL10_BIT])
        next_sdram_addr = col_phase ? col10 : row10;
      else
        next_sdram_addr = col_phase ? col9 : row9;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sdram_addr <= {AW{1'b0}};
      page_mode  <= 1'b0;
      port_size  <= 2'h0;
      map_ok     <= 1'b0;
    end
    else
    begin
      sdram_addr <= next_sdram_addr;
      page_mode  <= ctrl_reg[lat_blk][`SBD_PM_BIT];
      port_size  <= ctrl_reg[lat_blk][`SBD_PS_HI:`SBD_PS_LO];
      map_ok     <= (ctrl_reg[lat_blk][`SBD_PS_HI:`SBD_PS_LO] == `SBD_PS_8BIT);
    end
  end

  always @*
  begin
    next_prdata = 32'h00000000;
    if (paddr == `SBD_OFF_MASK0)
      next_prdata = mask_reg[0];
    else if (paddr == `SBD_OFF_MASK1)
      next_prdata = mask_reg[1];
    else if (paddr == `SBD_OFF_CTRL0)
      next_prdata = ctrl_reg[0];
    else if (paddr == `SBD_OFF_CTRL1)
      next_prdata = ctrl_reg[1];
    else if (paddr == `SBD_OFF_IRQ_STAT)
      next_prdata = {28'h0000000, irq_stat};
    else if (paddr == `SBD_OFF_IRQ_MASK)
      next_prdata = {28'h0000000, irq_mask};
    else if (paddr == `SBD_OFF_HIT_STAT)
      next_prdata = {28'h0000000, lat_blk, ext_cycle, blk_hit};
  end

  // read data registered in the setup cycle, valid in the access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable)
      prdata <= next_prdata;
  end
endmodule
`default_nettype wire

// ---- hw/sbd_defs.vh ----
`ifndef SBD_DEFS_VH
`define SBD_DEFS_VH
// register byte offsets
`define SBD_OFF_MASK0      8'h00
`define SBD_OFF_MASK1      8'h04
`define SBD_OFF_CTRL0      8'h08
`define SBD_OFF_CTRL1      8'h0C
`define SBD_OFF_IRQ_STAT   8'h10
`define SBD_OFF_IRQ_MASK   8'h14
`define SBD_OFF_HIT_STAT   8'h18
// mask register fields
`define SBD_BAM_HI         31
`define SBD_BAM_LO         18
`define SBD_WP_BIT         8
`define SBD_ATM_HI         6
`define SBD_ATM_LO         1
`define SBD_VALID_BIT      0
`define SBD_MASK_RST       32'h00000000
// control register fields
`define SBD_BASE_HI        31
`define SBD_BASE_LO        18
`define SBD_PS_HI          5
`define SBD_PS_LO          4
`define SBD_PM_BIT         2
`define SBD_COL10_BIT      0
`define SBD_CTRL_RST       32'h00000000
`define SBD_PS_8BIT        2'h1
// interrupt status bits
`define SBD_EV_EXC         0
`define SBD_EV_EXT         1
`define SBD_EV_MISS        2
`define SBD_EV_W           3
`endif

// ---- test/sbd_decode_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module sbd_decode_props #(parameter AW = 23) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic [7:0]    paddr,
  input wire logic          pslverr,
  input wire logic          acc_valid,
  input wire logic          acc_write,
  input wire logic          cs_match,
  input wire logic          col_phase,
  input wire logic [1:0]    blk_hit,
  input wire logic          addr_exc,
  input wire logic          ext_cycle,
  input wire logic          map_ok,
  input wire logic [AW-1:0] sdram_addr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence quiet;
    blk_hit == 2'h0 && !addr_exc && !ext_cycle;
  endsequence
  one_block_a: assert property (blk_hit != 2'h3)
    else $error("two blocks hit at once");
  exc_cause_a: assert property (addr_exc |-> $past(acc_valid && acc_write && !cs_match))
    else $error("exception without protected write");
  ext_cause_a: assert property (ext_cycle |-> $past(acc_valid && acc_write && cs_match))
    else $error("external cycle without chip select");
  prot_nohit_a: assert property (addr_exc || ext_cycle |-> blk_hit == 2'h0 && !(addr_exc && ext_cycle))
    else $error("protected write also hit");
  idle_quiet_a: assert property (!acc_valid |=> quiet)
    else $error("result without request");
  col_upper_a: assert property (map_ok && $past(col_phase) |-> sdram_addr[AW-1:10] == 0)
    else $error("column phase drives upper lines");
  size_off_a: assert property (!map_ok |-> sdram_addr == 0)
    else $error("address driven for other port size");
  unmapped_err_a: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
    else $error("unmapped access not refused");
endmodule
`default_nettype wire

// ---- test/sbd_sdram_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module sbd_sdram_model #(parameter LINES = 13) (
  input wire logic        pclk,
  input wire logic        col_phase,
  input wire logic [22:0] sdram_addr
);
  // only the low lines reach the part, the rest stay open
  logic [LINES-1:0] row_q;
  logic [LINES-1:0] col_q;
  // one 8-bit port formed by the parts side by side
  always @(posedge pclk)
    if (col_phase)
      col_q <= sdram_addr[LINES-1:0];
    else
      row_q <= sdram_addr[LINES-1:0];
endmodule
`default_nettype wire

// ---- test/tb_sdram_block_decode_and_addr_mux.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sbd_defs.vh"
module tb_sdram_block_decode_and_addr_mux;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic        acc_valid = 0, acc_write = 0, cs_match = 0, col_phase = 0;
  logic        pready, pslverr, addr_exc, ext_cycle, page_mode, map_ok, irq;
  logic [7:0]  paddr = 8'h00;
  logic [5:0]  acc_type = 6'h00;
  logic [1:0]  blk_hit, port_size, eh;
  logic [22:0] sdram_addr;
  logic [31:0] pwdata = 32'h0, acc_addr = 32'h0, prdata, rd, a, r;
  logic [31:0] msk [2], ctl [2];
  int          fail_count = 0, checks = 0, i, k;
  always #10 pclk = ~pclk;
  sbd_decode DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write), .acc_type(acc_type),
    .cs_match(cs_match), .col_phase(col_phase), .blk_hit(blk_hit), .addr_exc(addr_exc),
    .ext_cycle(ext_cycle), .page_mode(page_mode), .port_size(port_size), .map_ok(map_ok),
    .sdram_addr(sdram_addr), .irq(irq));
  sbd_sdram_model u_mem (.pclk(pclk), .col_phase(col_phase), .sdram_addr(sdram_addr));
  task test_done;
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fail_count++;
      test_done;
    end
    rd = prdata; e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  function logic hitb(int n, logic [31:0] ad, logic [5:0] t);
    return msk[n][0] && (((ad ^ ctl[n]) & ~msk[n]) >> 18) == 0 && (t & msk[n][6:1]) == 0;
  endfunction
  function logic [22:0] mux(logic [31:0] ad, logic c, logic c10);
    logic [22:0] m;
    for (int j = 0; j < 9; j++) m[j] = c ? ad[j] : ad[17-j];
    if (c) m[22:9] = {13'h0, c10 & ad[18]};
    else if (c10) m[22:9] = {1'b0, ad[31:20], ad[19]};
    else m[22:9] = ad[31:18];
    return m;
  endfunction
  task acc(input logic [31:0] ad, input logic w, input logic [5:0] t, input logic cs, input logic c);
    logic h0, h1, s, pr;
    logic [22:0] m;
    acc_valid <= 1; acc_addr <= ad; acc_write <= w; acc_type <= t; cs_match <= cs; col_phase <= c;
    h0 = hitb(0, ad, t); h1 = hitb(1, ad, t); s = !h0;
    pr = (h0 | h1) && w && msk[s][8];
    eh = pr ? 2'h0 : {h1 & !h0, h0};
    m = ctl[s][5:4] == `SBD_PS_8BIT ? mux(ad, c, ctl[s][0]) : 23'h0;
    @(posedge pclk);
    acc_valid <= 0;
    @(negedge pclk);
    chk("blk_hit", blk_hit, eh);
    chk("addr_exc", addr_exc, pr & !cs);
    chk("ext_cycle", ext_cycle, pr & cs);
    @(posedge pclk);
    @(negedge pclk);
    if (eh != 0)
    begin
      chk("port_size", port_size, ctl[s][5:4]);
      chk("page_mode", page_mode, ctl[s][2]);
      chk("sdram_addr", sdram_addr, m);
    end
    @(posedge pclk);
    @(negedge pclk);
    if (eh != 0)
      chk("sdram lines", c ? u_mem.col_q : u_mem.row_q, m[12:0]);
    @(posedge pclk);
  endtask
  initial
  begin
    void'($urandom(32'h9E2C));
    msk = '{0, 0};
    ctl = '{0, 0};
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (i = 0; i < 8; i++)
    begin
      apb(0, 8'(i * 4), 0);
      chk("reset value", rd, 0);
      chk("pslverr", e, i == 7);
    end
    acc(32'h0, 0, 6'h01, 0, 0);
    chk("irq masked", irq, 0);
    apb(1, `SBD_OFF_IRQ_MASK, 4);
    @(posedge pclk);
    chk("irq", irq, 1);
    apb(1, `SBD_OFF_IRQ_STAT, 4);
    @(posedge pclk);
    chk("irq cleared", irq, 0);
    for (i = 0; i < 300; i++)
    begin
      // valid goes last so a block never decodes half set up
      if (i % 30 == 0)
        for (k = 0; k < 2; k++)
        begin
          ctl[k] = $urandom & 32'hFFFC0035;
          msk[k] = $urandom & 32'hFFFC017F;
          apb(1, 8'(`SBD_OFF_CTRL0 + k * 4), ctl[k]);
          apb(1, 8'(`SBD_OFF_MASK0 + k * 4), msk[k]);
          apb(0, 8'(`SBD_OFF_MASK0 + k * 4), 0);
          chk("mask readback", rd, msk[k]);
        end
      r = $urandom;
      k = r[0];
      a = (ctl[k] & 32'hFFFC0000) | ($urandom & 32'h3FFFF);
      if (r[2:1] == 0) a ^= 32'h1 << (18 + r[7:4] % 14);
      acc(a, r[8], 6'h1 << (r[15:12] % 6), r[9], r[10]);
    end
    test_done;
  end
endmodule
bind sbd_decode sbd_decode_props #(.AW(AW)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pslverr(pslverr), .acc_valid(acc_valid), .acc_write(acc_write),
  .cs_match(cs_match), .col_phase(col_phase), .blk_hit(blk_hit), .addr_exc(addr_exc),
  .ext_cycle(ext_cycle), .map_ok(map_ok), .sdram_addr(sdram_addr));
`default_nettype wire
